//--- core/mdc_dma.sv
// Multichannel DMA controller with AHB-Lite register slave
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`include "mdc_consts.svh"

module mdc_dma #(
	parameter int NCH = 32
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             ce,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output      logic             hreadyout,
	output      logic             hresp,
	output      logic [31:0]      hrdata,
	input  wire logic [NCH-1:0]   dma_req,
	input  wire logic [NCH-1:0]   dma_sreq,
	output      logic             mem_req,
	output      logic             mem_we,
	output      logic [31:0]      mem_addr,
	output      logic [31:0]      mem_wdata,
	output      logic [1:0]       mem_size,
	input  wire logic             mem_ack,
	input  wire logic [31:0]      mem_rdata,
	input  wire logic             mem_err,
	output      logic             master_done_irq,
	output      logic             routed_irq_one,
	output      logic             routed_irq_two,
	output      logic             routed_irq_three,
	output      logic             bus_error_irq
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [5:0] mdc_pick(input logic [NCH-1:0] elig,
						input logic [NCH-1:0] hi);
		logic [5:0] r;
		r = 6'h00;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (elig[i]) begin
				r = {1'b1, 5'(i)};
			end
		end
		for (int i = NCH - 1; i >= 0; i--) begin
			if (elig[i] && hi[i]) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] mdc_step(input logic [1:0] s);
		return (s == `MDC_STEP_NONE) ? 32'h0000_0000 : (32'h0000_0001 << s);
	endfunction

	function automatic logic mdc_is_task(input logic [2:0] m);
		return m == mdc_pkg::mode_memory_task_list ||
		       m == mdc_pkg::mode_peripheral_task_list;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic                gen;
	logic [31:0]         ctrl_base;
	logic [NCH-1:0]      en, pend, req_mask, hi_prio, burst_only, alt_sel;
	logic [NCH-1:0]      sg_run, sg_last, sg_per, tail, done_st;
	logic                err_flag;
	logic [5:0]          route1, route2, route3;
	logic [NCH-1:0]      dreq_m, dreq_s, sreq_m, sreq_s;
	logic                ph_valid, ph_write;
	logic [7:0]          ph_addr;
	mdc_pkg::mdc_state_t st;
	logic [4:0]          cur_ch;
	logic                cur_alt;
	logic [1:0]          idx;
	logic [31:0]         src, dst, ctl, data;
	logic [2:0]          mode_r;
	logic [10:0]         arb_cnt;

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire         wr = ph_valid & ph_write;
	wire         wr_cfg = wr & (ph_addr == `MDC_OFS_CFG);
	wire         wr_base = wr & (ph_addr == `MDC_OFS_BASE);
	wire         wr_en_set = wr & (ph_addr == `MDC_OFS_EN_SET);
	wire         wr_en_clr = wr & (ph_addr == `MDC_OFS_EN_CLR);
	wire         wr_sw_req = wr & (ph_addr == `MDC_OFS_SW_REQ);
	wire         wr_mask = wr & (ph_addr == `MDC_OFS_REQ_MASK);
	wire         wr_prio = wr & (ph_addr == `MDC_OFS_HIGH_PRIO);
	wire         wr_burst = wr & (ph_addr == `MDC_OFS_BURST_ONLY);
	wire         wr_alt = wr & (ph_addr == `MDC_OFS_ALT_SEL);
	wire         wr_stat = wr & (ph_addr == `MDC_OFS_INT_STAT);
	wire         wr_err = wr & (ph_addr == `MDC_OFS_ERR);
	wire         wr_r1 = wr & (ph_addr == `MDC_OFS_ROUTE1);
	wire         wr_r2 = wr & (ph_addr == `MDC_OFS_ROUTE2);
	wire         wr_r3 = wr & (ph_addr == `MDC_OFS_ROUTE3);
	wire [NCH-1:0] wd = hwdata[NCH-1:0];
	wire [31:0]  alt_base = ctrl_base | `MDC_ALT_OFS;

	// Channels owned by a configurable line leave the zero mask
	logic [NCH-1:0] routed;
	for (genvar g = 0; g < NCH; g++) begin : g_route
		assign routed[g] = (route1[5] && route1[4:0] == 5'(g)) ||
				   (route2[5] && route2[4:0] == 5'(g)) ||
				   (route3[5] && route3[4:0] == 5'(g));
	end
	wire [NCH-1:0] stat_vis = done_st & ~routed;

	wire [31:0] rd_mux =
		(ph_addr == `MDC_OFS_CFG)        ? {31'h0000_0000, gen} :
		(ph_addr == `MDC_OFS_BASE)       ? ctrl_base :
		(ph_addr == `MDC_OFS_ALT_BASE)   ? alt_base :
		(ph_addr == `MDC_OFS_EN_SET)     ? 32'(en) :
		(ph_addr == `MDC_OFS_EN_CLR)     ? 32'(en) :
		(ph_addr == `MDC_OFS_REQ_MASK)   ? 32'(req_mask) :
		(ph_addr == `MDC_OFS_HIGH_PRIO)  ? 32'(hi_prio) :
		(ph_addr == `MDC_OFS_BURST_ONLY) ? 32'(burst_only) :
		(ph_addr == `MDC_OFS_ALT_SEL)    ? 32'(alt_sel) :
		(ph_addr == `MDC_OFS_INT_STAT)   ? 32'(stat_vis) :
		(ph_addr == `MDC_OFS_ERR)        ? {31'h0000_0000, err_flag} :
		(ph_addr == `MDC_OFS_ROUTE1)     ? {26'h000_0000, route1} :
		(ph_addr == `MDC_OFS_ROUTE2)     ? {26'h000_0000, route2} :
		(ph_addr == `MDC_OFS_ROUTE3)     ? {26'h000_0000, route3} :
		32'h0000_0000;

	// ----------------------------------------------------------------
	// Request qualification and arbitration
	// ----------------------------------------------------------------
	wire [NCH-1:0] tail_blk = tail & sg_last & alt_sel;
	wire [NCH-1:0] req_now = (dreq_s & ~req_mask) |
		(sreq_s & ~req_mask & ~burst_only & ~tail_blk);
	wire [NCH-1:0] sw_req = wr_sw_req ? wd : '0;
	wire [5:0]   pick = mdc_pick(en & pend, hi_prio);
	wire         start = (st == mdc_pkg::ST_IDLE) & gen & pick[5];
	wire [NCH-1:0] pick_oh = NCH'(1) << pick[4:0];
	wire [NCH-1:0] ch_oh = NCH'(1) << cur_ch;

	// ----------------------------------------------------------------
	// Engine events
	// ----------------------------------------------------------------
	wire         acked = mem_req & mem_ack;
	wire         err_evt = acked & mem_err;
	wire [2:0]   rd_mode = mem_rdata[`MDC_F_MODE +: 3];
	wire         fetch_end = (st == mdc_pkg::ST_FETCH) & acked & ~mem_err &
				 (idx == 2'h2);
	wire         halted_fetch = fetch_end & (rd_mode == mdc_pkg::mode_halted);
	wire         tl_prim = mdc_is_task(mode_r) & ~cur_alt;
	wire [10:0]  cnt = ctl[`MDC_F_CNT +: `MDC_CNT_W];
	wire         dec = ~tl_prim | (arb_cnt == 11'h001);
	wire         last_item = dec & (cnt == 11'h001);
	wire         basic_stop = (mode_r == mdc_pkg::mode_request_driven) &
				  ~req_now[cur_ch];
	wire [3:0]   arb_raw = mem_rdata[`MDC_F_ARB +: 4];
	wire [3:0]   arb_v = (arb_raw > `MDC_ARB_MAX) ? `MDC_ARB_MAX : arb_raw;
	wire [1:0]   sinc = ctl[`MDC_F_SINC +: 2];
	wire [1:0]   dinc = ctl[`MDC_F_DINC +: 2];
	wire [31:0]  sa = {ctrl_base[31:10], cur_alt, cur_ch, idx, 2'h0};

	wire         fin = (st == mdc_pkg::ST_BACK) & acked & ~mem_err &
			   (idx == 2'h2);
	wire         cnt0 = (cnt == 11'h000);
	wire         c_task = tl_prim;
	wire         c_ret = cur_alt & sg_run[cur_ch] & cnt0;
	wire         c_last = c_ret & sg_last[cur_ch];
	wire         c_pp = (mode_r == mdc_pkg::mode_double_buffer) & cnt0 &
			    ~c_ret;
	wire         c_end = cnt0 & ~c_task & ~c_ret & ~c_pp;
	wire         finish = fin & (c_last | c_end);
	wire         done_pulse = fin & (c_pp | c_last | c_end);
	wire         again = fin & (c_task | c_pp |
		(c_ret & ~c_last & ~sg_per[cur_ch]) |
		(~cnt0 & (mode_r != mdc_pkg::mode_request_driven)));
	wire [NCH-1:0] dis = (finish | halted_fetch | err_evt) ? ch_oh : '0;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dreq_m <= '0;
			dreq_s <= '0;
			sreq_m <= '0;
			sreq_s <= '0;
		end else if (ce) begin
			dreq_m <= dma_req;
			dreq_s <= dreq_m;
			sreq_m <= dma_sreq;
			sreq_s <= sreq_m;
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave, one wait state
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid  <= 1'b0;
			ph_write  <= 1'b0;
			ph_addr   <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= `MDC_RST_WORD;
		end else if (ce) begin
			if (hsel && htrans[1] && hready) begin
				ph_valid  <= 1'b1;
				ph_write  <= hwrite;
				ph_addr   <= haddr[7:0];
				hreadyout <= 1'b0;
			end else if (ph_valid) begin
				ph_valid  <= 1'b0;
				hreadyout <= 1'b1;
				hrdata    <= ph_write ? `MDC_RST_WORD : rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// Global and per-channel configuration
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gen        <= 1'b0;
			ctrl_base  <= `MDC_RST_WORD;
			req_mask   <= '0;
			hi_prio    <= '0;
			burst_only <= '0;
			route1     <= `MDC_RST_ROUTE;
			route2     <= `MDC_RST_ROUTE;
			route3     <= `MDC_RST_ROUTE;
		end else if (ce) begin
			if (wr_cfg) gen <= hwdata[0];
			if (wr_base) ctrl_base <= hwdata & `MDC_BASE_MASK;
			if (wr_mask) req_mask <= wd;
			if (wr_prio) hi_prio <= wd;
			if (wr_burst) burst_only <= wd;
			if (wr_r1) route1 <= hwdata[5:0];
			if (wr_r2) route2 <= hwdata[5:0];
			if (wr_r3) route3 <= hwdata[5:0];
		end
	end

	// ----------------------------------------------------------------
	// Channel status; hardware set wins over software clear, except alt_sel, where a register write wins over hardware
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en       <= '0;
			pend     <= '0;
			alt_sel  <= '0;
			sg_run   <= '0;
			sg_last  <= '0;
			sg_per   <= '0;
			tail     <= '0;
			done_st  <= '0;
			err_flag <= 1'b0;
		end else if (ce) begin
			en <= (en & ~dis & ~(wr_en_clr ? wd : '0)) |
			      (wr_en_set ? wd : '0);
			pend <= (pend & ~(start ? pick_oh : '0)) |
				(gen ? (req_now | sw_req) : '0) |
				(again ? ch_oh : '0);
			if (wr_alt) begin
				alt_sel <= wd;
			end else if (fin && c_task) begin
				alt_sel <= alt_sel | ch_oh;
			end else if (fin && (c_ret || finish)) begin
				alt_sel <= alt_sel & ~ch_oh;
			end else if (fin && c_pp) begin
				alt_sel <= alt_sel ^ ch_oh;
			end
			if (fin && c_task) begin
				sg_run  <= sg_run | ch_oh;
				sg_last <= cnt0 ? (sg_last | ch_oh) : (sg_last & ~ch_oh);
				sg_per  <= (mode_r == mdc_pkg::mode_peripheral_task_list) ?
					   (sg_per | ch_oh) : (sg_per & ~ch_oh);
				tail    <= ctl[`MDC_F_TAIL] ? (tail | ch_oh) :
					   (tail & ~ch_oh);
			end else if (finish || err_evt) begin
				sg_run  <= sg_run & ~ch_oh;
				sg_last <= sg_last & ~ch_oh;
			end
			done_st <= (done_st & ~(wr_stat ? wd : '0)) |
				   (done_pulse ? ch_oh : '0);
			err_flag <= (err_flag & ~(wr_err & (hwdata != 32'h0000_0000))) |
				    err_evt;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt outputs
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			master_done_irq  <= 1'b0;
			routed_irq_one   <= 1'b0;
			routed_irq_two   <= 1'b0;
			routed_irq_three <= 1'b0;
			bus_error_irq    <= 1'b0;
		end else if (ce) begin
			master_done_irq  <= |stat_vis;
			routed_irq_one   <= done_pulse & route1[5] & (route1[4:0] == cur_ch);
			routed_irq_two   <= done_pulse & route2[5] & (route2[4:0] == cur_ch);
			routed_irq_three <= done_pulse & route3[5] & (route3[4:0] == cur_ch);
			bus_error_irq    <= err_flag | err_evt;
		end
	end

	// ----------------------------------------------------------------
	// Transfer engine
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st        <= mdc_pkg::ST_IDLE;
			cur_ch    <= 5'h00;
			cur_alt   <= 1'b0;
			idx       <= 2'h0;
			src       <= `MDC_RST_WORD;
			dst       <= `MDC_RST_WORD;
			ctl       <= `MDC_RST_WORD;
			data      <= `MDC_RST_WORD;
			mode_r    <= mdc_pkg::mode_halted;
			arb_cnt   <= 11'h000;
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_addr  <= `MDC_RST_WORD;
			mem_wdata <= `MDC_RST_WORD;
			mem_size  <= 2'h0;
		end else if (ce) begin
			case (st)
			mdc_pkg::ST_IDLE: begin
				if (start) begin
					cur_ch  <= pick[4:0];
					cur_alt <= alt_sel[pick[4:0]];
					idx     <= 2'h0;
					st      <= mdc_pkg::ST_FETCH;
				end
			end
			mdc_pkg::ST_FETCH: begin
				if (!mem_req) begin
					mem_req  <= 1'b1;
					mem_we   <= 1'b0;
					mem_addr <= sa;
					mem_size <= 2'h2;
				end else if (mem_ack) begin
					mem_req <= 1'b0;
					idx     <= idx + 2'h1;
					if (idx == 2'h0) src <= mem_rdata;
					if (idx == 2'h1) dst <= mem_rdata;
					if (idx == 2'h2) ctl <= mem_rdata;
					mode_r  <= rd_mode;
					arb_cnt <= (mdc_is_task(rd_mode) && !cur_alt) ?
						   `MDC_TASK_WORDS : (11'h001 << arb_v);
					if (mem_err || halted_fetch) begin
						st <= mdc_pkg::ST_IDLE;
					end else if (idx == 2'h2) begin
						idx <= 2'h0;
						st  <= mdc_pkg::ST_READ;
					end
				end
			end
			mdc_pkg::ST_READ: begin
				if (!mem_req) begin
					mem_req  <= 1'b1;
					mem_we   <= 1'b0;
					mem_addr <= src;
					mem_size <= ctl[`MDC_F_SIZE +: 2];
				end else if (mem_ack) begin
					mem_req <= 1'b0;
					data    <= mem_rdata;
					st      <= mem_err ? mdc_pkg::ST_IDLE : mdc_pkg::ST_WRITE;
				end
			end
			mdc_pkg::ST_WRITE: begin
				if (!mem_req) begin
					mem_req   <= 1'b1;
					mem_we    <= 1'b1;
					mem_addr  <= dst;
					mem_wdata <= data;
				end else if (mem_ack) begin
					mem_req <= 1'b0;
					src     <= src + mdc_step(sinc);
					dst     <= dst + mdc_step(dinc);
					arb_cnt <= arb_cnt - 11'h001;
					if (dec) begin
						ctl[`MDC_F_CNT +: `MDC_CNT_W] <= cnt - 11'h001;
					end
					if (last_item) begin
						ctl[`MDC_F_MODE +: 3] <= mdc_pkg::mode_halted;
					end
					if (mem_err) begin
						st <= mdc_pkg::ST_IDLE;
					end else if (last_item || arb_cnt == 11'h001 || basic_stop) begin
						st <= mdc_pkg::ST_BACK;
					end else begin
						st <= mdc_pkg::ST_READ;
					end
				end
			end
			mdc_pkg::ST_BACK: begin
				if (!mem_req) begin
					mem_req   <= 1'b1;
					mem_we    <= 1'b1;
					mem_addr  <= sa;
					mem_size  <= 2'h2;
					mem_wdata <= (idx == 2'h0) ? src :
						     (idx == 2'h1) ? dst : ctl;
				end else if (mem_ack) begin
					mem_req <= 1'b0;
					idx     <= idx + 2'h1;
					if (mem_err || idx == 2'h2) begin
						idx <= 2'h0;
						st  <= mdc_pkg::ST_IDLE;
					end
				end
			end
			default: st <= mdc_pkg::ST_IDLE;
			endcase
		end
	end

endmodule

//--- pkg/mdc_consts.svh
// Register offsets, control word fields and reset values of the DMA core
`ifndef MDC_CONSTS_SVH
`define MDC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MDC_OFS_CFG        8'h00
`define MDC_OFS_BASE       8'h04
`define MDC_OFS_ALT_BASE   8'h08
`define MDC_OFS_EN_SET     8'h0C
`define MDC_OFS_EN_CLR     8'h10
`define MDC_OFS_SW_REQ     8'h14
`define MDC_OFS_REQ_MASK   8'h18
`define MDC_OFS_HIGH_PRIO  8'h1C
`define MDC_OFS_BURST_ONLY 8'h20
`define MDC_OFS_ALT_SEL    8'h24
`define MDC_OFS_INT_STAT   8'h28
`define MDC_OFS_ERR        8'h2C
`define MDC_OFS_ROUTE1     8'h30
`define MDC_OFS_ROUTE2     8'h34
`define MDC_OFS_ROUTE3     8'h38

// ----------------------------------------------------------------
// Control table layout
// ----------------------------------------------------------------
`define MDC_BASE_MASK      32'hFFFF_FC00
`define MDC_ALT_OFS        32'h0000_0200

// ----------------------------------------------------------------
// Control word fields
// ----------------------------------------------------------------
`define MDC_F_MODE         0
`define MDC_F_TAIL         3
`define MDC_F_CNT          4
`define MDC_CNT_W          11
`define MDC_F_ARB          15
`define MDC_ARB_MAX        4'hA
`define MDC_F_SINC         20
`define MDC_F_DINC         22
`define MDC_F_SIZE         24
`define MDC_TASK_WORDS     11'h004
`define MDC_STEP_NONE      2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MDC_RST_WORD       32'h0000_0000
`define MDC_RST_ROUTE      6'h00

`endif

//--- pkg/mdc_pkg.sv
// Types shared by the DMA core
package mdc_pkg;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_FETCH = 5'h02,
		ST_READ  = 5'h04,
		ST_WRITE = 5'h08,
		ST_BACK  = 5'h10
	} mdc_state_t;

	typedef enum logic [2:0] {
		mode_halted               = 3'h0,
		mode_request_driven       = 3'h1,
		mode_run_to_end           = 3'h2,
		mode_double_buffer        = 3'h3,
		mode_memory_task_list     = 3'h4,
		mode_peripheral_task_list = 3'h5
	} mdc_mode_t;
endpackage

//--- verification/mdc_dma_asserts.sv
// Port-level assertions for the DMA core
module mdc_dma_asserts (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        ce,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic        mem_ack,
	input wire logic        mem_err,
	input wire logic        routed_irq_one,
	input wire logic        bus_error_irq
);
	wire tk = hsel & htrans[1] & hready & ce;
	wire mx = mem_req & mem_ack;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	a_bus_wait: assert property (tk |=> !hreadyout ##1 hreadyout)
		else $error("wait state not one cycle");
	a_wait_cause: assert property (!hreadyout |-> $past(tk))
		else $error("wait state without transfer");
	a_write_rdata: assert property (tk && hwrite |-> ##2 hrdata == 32'h0)
		else $error("read data not cleared by write");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response");
	a_mem_hold: assert property (mem_req && !mem_ack |=>
		mem_req && $stable(mem_addr))
		else $error("memory request dropped early");
	a_mem_gap: assert property (mx |=> !mem_req)
		else $error("no gap after memory access");
	a_err_flag: assert property (mx && mem_err |-> ##[1:3] bus_error_irq)
		else $error("error interrupt missing");
	a_routed_pulse: assert property (routed_irq_one |=> !routed_irq_one)
		else $error("routed interrupt too long");
endmodule

bind mdc_dma mdc_dma_asserts mdc_dma_asserts_inst (.*);

//--- verification/mdc_mem_model.sv
// Behavioural memory answering the DMA master port
module mdc_mem_model (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	input  wire logic        slow,
	input  wire logic        err_on,
	output      logic        mem_ack,
	output      logic [31:0] mem_rdata,
	output      logic        mem_err
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [logic [29:0]];
	int          cnt;
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= 32'h5A5A_A5A5;
			cnt = 0;
		end else if (mem_req && !mem_ack && cnt >= (slow ? 3 : 0)) begin
			mem_ack <= 1'b1;
			mem_err <= err_on;
			cnt = 0;
			if (mem_we)
				mem[mem_addr[31:2]] = mem_wdata;
			else if (mem.exists(mem_addr[31:2]))
				mem_rdata <= mem[mem_addr[31:2]];
		end else begin
			// Idle bus shows changing data
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack)
				cnt++;
		end
	end
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the DMA core
`include "mdc_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] TBL = 32'h0000_1000;
	localparam logic [31:0] SRC = 32'h0000_2000;
	localparam logic [31:0] DST = 32'h0000_3000;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        ce = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic        slow = 1'b0;
	logic        err_on = 1'b0;
	logic        dp = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] dma_req = 32'h0;
	logic [31:0] dma_sreq = 32'h0;
	logic [31:0] seed = 32'h0001_5EA0;
	logic [31:0] b;
	logic [31:0] q [$];
	logic [7:0]  z [6] = '{`MDC_OFS_CFG, `MDC_OFS_BASE, `MDC_OFS_EN_SET,
		`MDC_OFS_INT_STAT, `MDC_OFS_ERR, 8'h3C};
	int          fail_count = 0;
	int          total_checks = 0;
	int          busy_n = 0;
	wire         hready;
	wire         hreadyout, hresp, mem_req, mem_we, mem_ack, mem_err;
	wire         master_done_irq, routed_irq_one, routed_irq_two;
	wire         routed_irq_three, bus_error_irq;
	wire  [31:0] hrdata, mem_addr, mem_wdata, mem_rdata;
	wire  [1:0]  mem_size;
	wire  [4:0]  irqs = {bus_error_irq, routed_irq_three, routed_irq_two,
		routed_irq_one, master_done_irq};
	assign hready = hreadyout;
	mdc_dma mdc_dma_inst (.*);
	mdc_mem_model mdc_mem_model_inst (.*);
	initial begin
		forever #2.5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (mem_req === 1'b1)
			busy_n++;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Word items, word steps
	function automatic logic [31:0] mk(input logic [2:0] m,
		input logic [10:0] n);
		return (32'h2 << `MDC_F_SIZE) | (32'h2 << `MDC_F_DINC) |
			(32'h2 << `MDC_F_SINC) | (32'h1 << `MDC_F_ARB) |
			(32'(n) << `MDC_F_CNT) | 32'(m);
	endfunction
	function automatic logic [31:0] rd(input logic [31:0] a);
		return mdc_mem_model_inst.mem[a[31:2]];
	endfunction
	task automatic wm(input logic [31:0] a, input logic [31:0] d);
		mdc_mem_model_inst.mem[a[31:2]] = d;
	endtask
	task automatic st(input int ch, input logic [31:0] s, d, c);
		wm(TBL + 32'(ch * 16), s);
		wm(TBL + 32'(ch * 16) + 32'h4, d);
		wm(TBL + 32'(ch * 16) + 32'h8, c);
	endtask
	task automatic results();
		$display("checks=%0d errors=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wrdy();
		for (int i = 0; i < 64; i++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				return;
		end
		fail_count++;
		results();
	endtask
	task automatic wfor(input int k);
		for (int i = 0; i < 400; i++) begin
			@(posedge hclk);
			if (irqs[k] === 1'b1)
				return;
		end
		fail_count++;
		results();
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		if (!w)
			q.push_back(d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wrdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wrdy();
	endtask
	// Read results as they appear
	always @(posedge hclk) begin
		if (dp && hreadyout === 1'b1) begin
			chk(hrdata, q.pop_front());
			dp = 1'b0;
		end
		if (hsel && htrans[1] && hreadyout && !hwrite)
			dp = 1'b1;
	end
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (z[i]) xfer(1'b0, z[i], 32'h0);
		b = rnd();
		xfer(1'b1, `MDC_OFS_BASE, b);
		xfer(1'b0, `MDC_OFS_BASE, b & `MDC_BASE_MASK);
		xfer(1'b1, `MDC_OFS_BASE, TBL);
		xfer(1'b1, `MDC_OFS_ALT_BASE, b);
		xfer(1'b0, `MDC_OFS_ALT_BASE, TBL | `MDC_ALT_OFS);
		st(0, SRC, DST, mk(3'h2, 11'h4));
		for (int i = 0; i < 4; i++)
			wm(SRC + 32'(4 * i), rnd());
		xfer(1'b1, `MDC_OFS_EN_SET, 32'h1);
		xfer(1'b1, `MDC_OFS_SW_REQ, 32'h1);
		repeat (20) @(posedge hclk);
		chk(32'(busy_n), 32'h0);
		xfer(1'b0, `MDC_OFS_EN_SET, 32'h1);
		slow <= 1'b1;
		xfer(1'b1, `MDC_OFS_REQ_MASK, 32'h1);
		xfer(1'b1, `MDC_OFS_CFG, 32'h1);
		xfer(1'b1, `MDC_OFS_SW_REQ, 32'h1);
		wfor(0);
		for (int i = 0; i < 4; i++)
			chk(rd(DST + 32'(4 * i)), rd(SRC + 32'(4 * i)));
		chk(rd(TBL), SRC + 32'h10);
		chk(rd(TBL + 32'h4), DST + 32'h10);
		chk(rd(TBL + 32'h8), mk(3'h0, 11'h0));
		xfer(1'b0, `MDC_OFS_EN_SET, 32'h0);
		xfer(1'b0, `MDC_OFS_INT_STAT, 32'h1);
		xfer(1'b1, `MDC_OFS_INT_STAT, 32'h1);
		xfer(1'b0, `MDC_OFS_INT_STAT, 32'h0);
		// Request-driven channel on the first routed line
		slow <= 1'b0;
		st(1, SRC, DST + 32'h40, mk(3'h1, 11'h2));
		xfer(1'b1, `MDC_OFS_ROUTE1, 32'h21);
		xfer(1'b1, `MDC_OFS_EN_SET, 32'h2);
		dma_sreq <= 32'h2;
		wfor(1);
		dma_sreq <= 32'h0;
		chk(rd(DST + 32'h44), rd(SRC + 32'h4));
		chk(rd(TBL + 32'h18), mk(3'h0, 11'h0));
		xfer(1'b0, `MDC_OFS_INT_STAT, 32'h0);
		chk(32'(master_done_irq), 32'h0);
		chk(32'(irqs[3:2]), 32'h0);
		// Bus error aborts the channel
		st(2, SRC, DST, mk(3'h2, 11'h1));
		err_on <= 1'b1;
		xfer(1'b1, `MDC_OFS_EN_SET, 32'h4);
		xfer(1'b1, `MDC_OFS_SW_REQ, 32'h4);
		wfor(4);
		err_on <= 1'b0;
		xfer(1'b0, `MDC_OFS_ERR, 32'h1);
		xfer(1'b0, `MDC_OFS_EN_SET, 32'h0);
		xfer(1'b1, `MDC_OFS_ERR, 32'h1);
		xfer(1'b0, `MDC_OFS_ERR, 32'h0);
		results();
	end
endmodule
